/* File: rtl/ebpm_pkg.sv */
// Package of types and constants for the external bus pin multiplexer
package ebpm_pkg;

	// ------------------------------------------------------------
	// Port 2 bit positions
	// ------------------------------------------------------------
	localparam int P2_BUFFER_CONTROL_OUT_BIT = 0;
	localparam int P2_HOLDACK_BIT = 1;
	localparam int P2_HOLDREQ_BIT = 2;
	localparam int P2_READY_BIT = 3;
	localparam int P2_CLK_BIT = 4;
	localparam int P2_WRITE_BIT = 5;
	localparam int P2_READ_BIT = 6;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;

	// ------------------------------------------------------------
	// Operating modes from the boot-select pins
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EBPM_MODE_SINGLE = 2'b00,
		EBPM_MODE_EXTBUS = 2'b01,
		EBPM_MODE_RSVD2 = 2'b10,
		EBPM_MODE_RSVD3 = 2'b11
	} ebpm_mode_t;

	// Core-side request for the external bus
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic addr_phase;
		logic data_drive;
		logic rd_strobe_n;
		logic wr_strobe_n;
		logic bus_clk;
		logic buf_ctl;
		logic hold_ack;
	} ebpm_bus_t;

	// Software port state
	typedef struct packed {
		logic [7:0] p0_data;
		logic [7:0] p0_dir;
		logic [7:0] p1_data;
		logic [7:0] p1_dir;
		logic [7:0] p2_data;
	} ebpm_gpio_t;

	// Bus-pin configuration bits
	typedef struct packed {
		logic buffer_control_out_en;
		logic hold_en;
	} ebpm_cfg_t;

	// Pad group: output, output enable
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} ebpm_pad8_t;

endpackage : ebpm_pkg

/* File: rtl/ebpm_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ebpm_sync import ebpm_pkg::*; #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : ebpm_sync

/* File: rtl/ebpm_reset_pin.sv */
// Open-drain reset pin driver and external reset capture
`timescale 1ns/10ps
module ebpm_reset_pin import ebpm_pkg::*; (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic int_reset_req,
	input wire logic rst_pin_n_sync,
	output logic rst_pin_oe,
	output logic ext_reset
);

	// ------------------------------------------------------------
	// Pin drive and capture
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rst_pin_oe <= 1'b0;
			ext_reset <= 1'b0;
		end else if (clk_en) begin
			rst_pin_oe <= int_reset_req; // see RULE1
			ext_reset <= ~rst_pin_n_sync; // see RULE2
		end
	end

	chk_rst_pin_drive: assert property ( // see RULE1
		@(posedge core_clk) disable iff (reset)
		clk_en && int_reset_req |=> rst_pin_oe)
		else $error("reset pin not driven for internal reset");

	chk_ext_reset_in: assert property ( // see RULE2
		@(posedge core_clk) disable iff (reset)
		clk_en && !rst_pin_n_sync |=> ext_reset)
		else $error("low reset pin not captured");

endmodule : ebpm_reset_pin

/* File: rtl/ebpm_pin_mux.sv */
// External bus pin multiplexer for ports 0 to 2 and the reset pin
// Notes on behaviour
// RULE1 - An internal reset source pulls the reset pin low by open drain.
// RULE2 - A low level on the reset pin resets the internal circuitry.
// RULE3 - The mode comes from the static boot-select pin levels.
// RULE4 - Without the bus, ports 0 and 1 are software GPIO bits.
// RULE5 - In bus mode port 0 carries the low address and data, muxed.
// RULE6 - In bus mode port 1 drives the upper address byte.
// RULE7 - Without the bus, port 2 outputs the port data register.
// RULE8 - In bus mode port 2 bit 0 is buffer control when enabled.
// RULE9 - In bus mode port 2 bit 1 is hold acknowledge when enabled.
// RULE10 - In bus mode port 2 bit 2 is hold request input when enabled.
// RULE11 - In bus mode port 2 bit 5 drives the write strobe.
// RULE12 - In bus mode port 2 bit 6 drives the read strobe.
// RULE13 - In bus mode port 2 bit 3 is ready in and bit 4 the bus clock.
`timescale 1ns/10ps
module ebpm_pin_mux import ebpm_pkg::*; (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic boot_select_0,
	input wire logic boot_select_1,
	input wire logic rst_pin_n_in,
	input wire logic int_reset_req,
	input wire ebpm_bus_t bus_req,
	input wire ebpm_gpio_t gpio,
	input wire ebpm_cfg_t bus_pin_config_register,
	input wire logic [7:0] port0_line_in,
	input wire logic [7:0] port1_line_in,
	input wire logic [7:0] port2_line_in,
	output logic rst_pin_oe,
	output logic core_reset,
	output logic ext_bus_mode,
	output ebpm_pad8_t port0_line,
	output ebpm_pad8_t port1_line,
	output ebpm_pad8_t port2_line,
	output logic [7:0] port0_rd,
	output logic [7:0] port1_rd,
	output logic [7:0] muxed_addr_data_line_rd,
	output logic hold_request_in,
	output logic ready_in
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [7:0] p0_s;
	logic [7:0] p1_s;
	logic [7:0] p2_s;
	logic [2:0] ctl_s;
	logic ext_reset;
	logic mode_valid_q;
	ebpm_mode_t mode_q;

	ebpm_sync #(.W(8), .INIT(8'h00)) u_sync_p0 (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in(port0_line_in),
		.sync_out(p0_s)
	);

	ebpm_sync #(.W(8), .INIT(8'h00)) u_sync_p1 (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in(port1_line_in),
		.sync_out(p1_s)
	);

	ebpm_sync #(.W(8), .INIT(8'hFF)) u_sync_p2 (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in(port2_line_in),
		.sync_out(p2_s)
	);

	ebpm_sync #(.W(3), .INIT(3'h4)) u_sync_ctl (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in({rst_pin_n_in, boot_select_1, boot_select_0}),
		.sync_out(ctl_s)
	);

	// ------------------------------------------------------------
	// Reset pin
	// ------------------------------------------------------------
	ebpm_reset_pin u_rst (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.int_reset_req(int_reset_req),
		.rst_pin_n_sync(ctl_s[2]),
		.rst_pin_oe(rst_pin_oe),
		.ext_reset(ext_reset)
	);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			core_reset <= 1'b1;
		end else if (clk_en) begin
			core_reset <= ext_reset | int_reset_req; // see RULE2
		end
	end

	// ------------------------------------------------------------
	// Mode capture
	// ------------------------------------------------------------
	function automatic logic is_ext_mode(input ebpm_mode_t m);
		return m == EBPM_MODE_EXTBUS;
	endfunction : is_ext_mode

	// Mode is sampled on every enabled cycle while the core is held in reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_q <= EBPM_MODE_SINGLE;
			mode_valid_q <= 1'b0;
			ext_bus_mode <= 1'b0;
		end else if (clk_en) begin
			if (core_reset) begin
				mode_q <= ebpm_mode_t'(ctl_s[1:0]); // see RULE3
				mode_valid_q <= 1'b1;
				ext_bus_mode <= 1'b0;
			end else begin
				ext_bus_mode <= mode_valid_q && is_ext_mode(mode_q);
			end
		end
	end

	// ------------------------------------------------------------
	// Port 0 and port 1
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			port0_line <= '{o: PORT_RESET, oe: DIR_RESET};
			port1_line <= '{o: PORT_RESET, oe: DIR_RESET};
		end else if (clk_en) begin
			if (core_reset) begin
				port0_line <= '{o: PORT_RESET, oe: DIR_RESET};
				port1_line <= '{o: PORT_RESET, oe: DIR_RESET};
			end else if (ext_bus_mode) begin
				if (bus_req.addr_phase) begin
					port0_line.o <= bus_req.addr[7:0]; // see RULE5
					port0_line.oe <= 8'hFF; // see RULE5
				end else begin
					port0_line.o <= bus_req.wdata; // see RULE5
					port0_line.oe <= {8{bus_req.data_drive}}; // see RULE5
				end
				port1_line.o <= bus_req.addr[15:8]; // see RULE6
				port1_line.oe <= 8'hFF; // see RULE6
			end else begin
				port0_line.o <= gpio.p0_data; // see RULE4
				port0_line.oe <= gpio.p0_dir; // see RULE4
				port1_line.o <= gpio.p1_data; // see RULE4
				port1_line.oe <= gpio.p1_dir; // see RULE4
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			port0_rd <= 8'h00;
			port1_rd <= 8'h00;
			muxed_addr_data_line_rd <= 8'h00;
		end else if (clk_en) begin
			port0_rd <= p0_s; // see RULE4
			port1_rd <= p1_s; // see RULE4
			muxed_addr_data_line_rd <= p0_s; // see RULE5
		end
	end

	// ------------------------------------------------------------
	// Port 2
	// ------------------------------------------------------------
	logic [7:0] p2_o_d;
	logic [7:0] p2_oe_d;

	always_comb begin
		p2_o_d = gpio.p2_data; // see RULE7
		p2_oe_d = 8'hFF; // see RULE7
		if (ext_bus_mode) begin
			if (bus_pin_config_register.buffer_control_out_en) begin
				p2_o_d[P2_BUFFER_CONTROL_OUT_BIT] = bus_req.buf_ctl; // see RULE8
			end
			if (bus_pin_config_register.hold_en) begin
				p2_o_d[P2_HOLDACK_BIT] = bus_req.hold_ack; // see RULE9
				p2_oe_d[P2_HOLDREQ_BIT] = 1'b0; // see RULE10
			end
			p2_oe_d[P2_READY_BIT] = 1'b0; // see RULE13
			p2_o_d[P2_CLK_BIT] = bus_req.bus_clk; // see RULE13
			p2_o_d[P2_WRITE_BIT] = bus_req.wr_strobe_n; // see RULE11
			p2_o_d[P2_READ_BIT] = bus_req.rd_strobe_n; // see RULE12
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			port2_line <= '{o: PORT_RESET, oe: DIR_RESET};
		end else if (clk_en) begin
			if (core_reset) begin
				port2_line <= '{o: PORT_RESET, oe: DIR_RESET};
			end else begin
				port2_line <= '{o: p2_o_d, oe: p2_oe_d};
			end
		end
	end

	// Inputs read as idle when their function is off
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hold_request_in <= 1'b0;
			ready_in <= 1'b1;
		end else if (clk_en) begin
			hold_request_in <= ext_bus_mode &&
				bus_pin_config_register.hold_en &&
				p2_s[P2_HOLDREQ_BIT]; // see RULE10
			ready_in <= !ext_bus_mode || p2_s[P2_READY_BIT]; // see RULE13
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_p1_upper_addr: assert property ( // see RULE6
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset |=>
		port1_line.oe == 8'hFF && port1_line.o == $past(bus_req.addr[15:8]))
		else $error("port 1 not carrying upper address");

	chk_p0_addr_phase: assert property ( // see RULE5
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset && bus_req.addr_phase |=>
		port0_line.oe == 8'hFF && port0_line.o == $past(bus_req.addr[7:0]))
		else $error("port 0 not carrying low address");

	chk_p0_data_phase: assert property ( // see RULE5
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset && !bus_req.addr_phase |=>
		port0_line.oe == {8{$past(bus_req.data_drive)}} &&
		port0_line.o == $past(bus_req.wdata))
		else $error("port 0 not carrying write data");

	chk_p0_gpio: assert property ( // see RULE4
		@(posedge core_clk) disable iff (reset)
		clk_en && !ext_bus_mode && !core_reset |=>
		port0_line.oe == $past(gpio.p0_dir))
		else $error("port 0 direction not from software");

	chk_p2_gpio: assert property ( // see RULE7
		@(posedge core_clk) disable iff (reset)
		clk_en && !ext_bus_mode && !core_reset |=>
		port2_line.o == $past(gpio.p2_data))
		else $error("port 2 not from data register");

	chk_wr_strobe: assert property ( // see RULE11
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset |=>
		port2_line.o[P2_WRITE_BIT] == $past(bus_req.wr_strobe_n))
		else $error("write strobe not on port 2 bit 5");

	chk_rd_strobe: assert property ( // see RULE12
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset |=>
		port2_line.o[P2_READ_BIT] == $past(bus_req.rd_strobe_n))
		else $error("read strobe not on port 2 bit 6");

	chk_buffer_control_out_gate: assert property ( // see RULE8
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset &&
		bus_pin_config_register.buffer_control_out_en |=>
		port2_line.o[P2_BUFFER_CONTROL_OUT_BIT] == $past(bus_req.buf_ctl))
		else $error("buffer control not on port 2 bit 0");

	chk_hold_pins: assert property ( // see RULE9 see RULE10
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset &&
		bus_pin_config_register.hold_en |=>
		!port2_line.oe[P2_HOLDREQ_BIT] &&
		port2_line.o[P2_HOLDACK_BIT] == $past(bus_req.hold_ack))
		else $error("hold pins not configured");

	chk_hold_req_off: assert property ( // see RULE10
		@(posedge core_clk) disable iff (reset)
		clk_en && !(ext_bus_mode && bus_pin_config_register.hold_en) |=>
		!hold_request_in)
		else $error("hold request seen while its function is off");

	chk_ready_clk: assert property ( // see RULE13
		@(posedge core_clk) disable iff (reset)
		clk_en && ext_bus_mode && !core_reset |=>
		!port2_line.oe[P2_READY_BIT] &&
		port2_line.o[P2_CLK_BIT] == $past(bus_req.bus_clk))
		else $error("ready or clock pin wrong");

	chk_reset_pads: assert property ( // see RULE2
		@(posedge core_clk) disable iff (reset)
		clk_en && core_reset |=>
		port0_line.oe == DIR_RESET && port1_line.oe == DIR_RESET &&
		port2_line.oe == DIR_RESET)
		else $error("pads driven while the core is in reset");

	chk_mode_hold: assert property ( // see RULE3
		@(posedge core_clk) disable iff (reset)
		clk_en && !core_reset |=> $stable(mode_q))
		else $error("mode changed outside reset");

	cov_ext_mode: cover property (@(posedge core_clk) ext_bus_mode);
	cov_hold_req: cover property (@(posedge core_clk) hold_request_in);
	cov_int_reset: cover property (@(posedge core_clk) rst_pin_oe);
	cov_data_phase: cover property (@(posedge core_clk)
		ext_bus_mode && !bus_req.addr_phase && bus_req.data_drive);

endmodule : ebpm_pin_mux

/* File: verif/ebpm_ext_mem.sv */
// Far-side model: external memory and bus master on the muxed bus
`timescale 1ns/10ps
module ebpm_ext_mem import ebpm_pkg::*; (
	input wire logic core_clk,
	input wire logic slow,
	input wire ebpm_pad8_t port0_line,
	input wire ebpm_pad8_t port1_line,
	input wire ebpm_pad8_t port2_line,
	output logic [7:0] port0_line_in,
	output logic [7:0] port1_line_in,
	output logic [7:0] port2_line_in
);
	logic [7:0] mem [256];
	logic [7:0] low_q = 8'h00;
	logic [7:0] noise_q = 8'h5A;
	logic ready_q = 1'b1;
	logic hold_q = 1'b0;
	logic reading;
	logic [7:0] far2;

	function automatic logic [7:0] res(input ebpm_pad8_t p,
		input logic [7:0] f);
		return (p.o & p.oe) | (f & ~p.oe);
	endfunction : res

	initial begin
		for (int k = 0; k < 256; k++) begin
			mem[k] = 8'(k) ^ 8'hA5;
		end
	end
	// Released lines show a pattern that moves every cycle, except port 2 bits 2 and 3 (hold, ready) and port 0 during a read
	always @(posedge core_clk) begin
		noise_q <= ~noise_q + 8'h01;
		ready_q <= slow ? 1'($urandom) : 1'b1;
		hold_q <= ($urandom % 16 == 0) ? ~hold_q : hold_q;
		if (port2_line.o[6] & port2_line.o[5] & port0_line.oe[0]) begin
			low_q <= port0_line.o;
		end
		if (port2_line.oe[5] & ~port2_line.o[5] & port0_line.oe[0]) begin
			mem[low_q] <= port0_line.o;
		end
	end
	assign reading = port2_line.oe[6] & ~port2_line.o[6] & ~port0_line.oe[0];
	always_comb begin
		far2 = ~noise_q;
		far2[2] = hold_q;
		far2[3] = ready_q;
		port0_line_in = res(port0_line, reading ? mem[low_q] : noise_q);
		port1_line_in = res(port1_line, noise_q);
		port2_line_in = res(port2_line, far2);
	end
endmodule : ebpm_ext_mem

/* File: verif/tb_top.sv */
// Self-checking bench for the external bus pin multiplexer
`timescale 1ns/10ps
module tb_top import ebpm_pkg::*;;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic boot_select_0 = 1'b0;
	logic boot_select_1 = 1'b0;
	logic ext_rst_n = 1'b1;
	logic int_reset_req = 1'b0;
	ebpm_bus_t bus_req = '0;
	ebpm_gpio_t gpio = '0;
	ebpm_cfg_t bus_pin_config_register = '0;
	logic [7:0] port0_line_in, port1_line_in, port2_line_in;
	logic rst_pin_oe, core_reset, ext_bus_mode, hold_request_in, ready_in;
	ebpm_pad8_t port0_line, port1_line, port2_line;
	logic [7:0] port0_rd, port1_rd, muxed_addr_data_line_rd;
	wire logic rst_pin_n_in = ~rst_pin_oe & ext_rst_n;
	logic slow = 1'b0;
	logic bus_on = 1'b0;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	ebpm_pad8_t e0, e1, e2;
	logic [23:0] hist [4] = '{default: '0};
	logic [55:0] frozen;

	ebpm_pin_mux dut (.core_clk, .reset, .clk_en, .boot_select_0,
		.boot_select_1, .rst_pin_n_in, .int_reset_req, .bus_req, .gpio,
		.bus_pin_config_register, .port0_line_in, .port1_line_in,
		.port2_line_in, .rst_pin_oe, .core_reset, .ext_bus_mode,
		.port0_line, .port1_line, .port2_line, .port0_rd, .port1_rd,
		.muxed_addr_data_line_rd, .hold_request_in, .ready_in);
	ebpm_ext_mem far_end (.core_clk, .slow, .port0_line, .port1_line,
		.port2_line, .port0_line_in, .port1_line_in, .port2_line_in);

	initial begin
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude();
		if (fail_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// Reference model of the pad drive
	// ------------------------------------------------------------
	function automatic void model(input logic bm);
		e0 = {gpio.p0_data, gpio.p0_dir};
		e1 = {gpio.p1_data, gpio.p1_dir};
		e2 = {gpio.p2_data, 8'hFF};
		if (bm) begin
			e0 = bus_req.addr_phase ? {bus_req.addr[7:0], 8'hFF} :
				{bus_req.wdata, {8{bus_req.data_drive}}};
			e1 = {bus_req.addr[15:8], 8'hFF};
			if (bus_pin_config_register.buffer_control_out_en) begin
				e2.o[0] = bus_req.buf_ctl;
			end
			if (bus_pin_config_register.hold_en) begin
				e2.o[1] = bus_req.hold_ack;
				e2.oe[2] = 1'b0;
			end
			e2.oe[3] = 1'b0;
			e2.o[6:4] = {bus_req.rd_strobe_n, bus_req.wr_strobe_n,
				bus_req.bus_clk};
		end
	endfunction : model

	task automatic step(input int n);
		logic [23:0] h;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			model(bus_on);
			for (int k = 3; k > 0; k--) begin
				hist[k] = hist[k - 1];
			end
			hist[0] = {port2_line_in, port1_line_in, port0_line_in};
			bus_req <= ebpm_bus_t'(31'($urandom));
			gpio <= ebpm_gpio_t'(40'({$urandom, $urandom}));
			@(negedge core_clk);
			check({port0_line.oe, port0_line.o & e0.oe},
				{e0.oe, e0.o & e0.oe});
			check({port1_line.oe, port1_line.o & e1.oe},
				{e1.oe, e1.o & e1.oe});
			check(port2_line.oe, e2.oe);
			check(port2_line.o & e2.oe,
				e2.o & e2.oe);
			if (i > 3) begin
				// Pin level sampled two edges ago reaches the read outputs now
				h = hist[2];
				check(port1_rd, h[15:8]);
				check(bus_on ? muxed_addr_data_line_rd : port0_rd,
					h[7:0]);
				check({ready_in, hold_request_in},
					{bus_on ? h[19] : 1'h1,
					bus_on & bus_pin_config_register.hold_en &
					h[18]});
			end
		end
	endtask : step

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(44506));
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			@(posedge core_clk);
			{boot_select_1, boot_select_0} <= 2'(m);
			bus_pin_config_register <= ebpm_cfg_t'(2'(m + 1));
			ext_rst_n <= 1'b0;
			repeat (6) @(posedge core_clk);
			@(negedge core_clk);
			check({core_reset, rst_pin_oe, port0_line.oe, port2_line.oe},
				18'h20000);
			ext_rst_n <= 1'b0;
			@(posedge core_clk);
			ext_rst_n <= 1'b1;
			bus_on = (m == 1);
			repeat (8) @(posedge core_clk);
			@(negedge core_clk);
			check({core_reset, ext_bus_mode}, {1'b0, bus_on});
			step(150);
		end
		@(posedge core_clk);
		{boot_select_1, boot_select_0} <= 2'b01;
		bus_pin_config_register <= ebpm_cfg_t'(2'b01);
		int_reset_req <= 1'b1;
		slow <= 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		check({rst_pin_oe, core_reset}, 2'b11);
		repeat (3) @(posedge core_clk);
		int_reset_req <= 1'b0;
		bus_on = 1'b1;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		check({rst_pin_oe, core_reset, ext_bus_mode}, 3'b001);
		step(300);
		// Clock enable low: pads and port0_rd must hold still
		@(posedge core_clk);
		clk_en <= 1'h0;
		@(negedge core_clk);
		frozen = {port0_line, port1_line, port2_line, port0_rd};
		for (int k = 0; k < 6; k++) begin
			@(posedge core_clk);
			bus_req <= ebpm_bus_t'(31'($urandom));
			gpio <= ebpm_gpio_t'(40'({$urandom, $urandom}));
		end
		@(negedge core_clk);
		check({port0_line, port1_line}, frozen[55:24]);
		check({port2_line, port0_rd}, frozen[23:0]);
		conclude();
	end
endmodule : tb_top
